// file: dpram_dev_model.sv
// Behavioural model of one RAM port with address busy logic
`timescale 1ns/100ps
`default_nettype none
module dpram_dev_model (
  // Clock
  input  wire logic                         mclk_i,
  // Host pins and resolved busy pin level
  input  wire dpram_host_pkg::pins_t        pins_i,
  input  wire logic                         busy_pin_i,
  // Other port holds the same location
  input  wire logic                         contend_i,
  // Toward host
  output logic [dpram_host_pkg::DATA_W-1:0] data_o,
  output logic                              busy_n_o
);
  logic [dpram_host_pkg::DATA_W-1:0] mem [0:8191];
  logic [dpram_host_pkg::DATA_W-1:0] last = 8'h00;
  logic                              rd;
  logic                              wr_ok;
  // Our flag starts pending, as if the peer had left a message
  logic                              own_int_n  = 1'b0;
  logic                              peer_int_n = 1'b1;
  // Other port is taken as first, so this port always loses
  assign busy_n_o = ~(contend_i && !pins_i.ce_n);
  assign rd = !pins_i.ce_n && !pins_i.oe_n && pins_i.rw_n;
  // Writes are gated by both our own busy drive and the busy pin level
  assign wr_ok = !pins_i.ce_n && !pins_i.rw_n
                 && busy_n_o && busy_pin_i;
  // Released bus shows the inverse of the last value, never a stale copy
  assign data_o = rd ? mem[pins_i.addr] : ~last;
  always @(posedge mclk_i) begin
    if (rd) begin
      last <= data_o;
    end
    // Busy low gates the strobe inside the array
    if (wr_ok) begin
      mem[pins_i.addr] <= pins_i.wdata;
    end
    // Mailbox at the top address raises the peer's flag
    if (wr_ok && pins_i.addr == 13'h1fff) begin
      peer_int_n <= 1'b0;
    end
    // Reading our own mailbox clears our flag
    if (rd && pins_i.addr == 13'h1ffe) begin
      own_int_n <= 1'b1;
    end
  end
endmodule : dpram_dev_model
`default_nettype wire

// file: dpram_host_pkg.sv
// Constants and carrier types for the dual-port RAM port controller
package dpram_host_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_WP_NS       = 12;
  localparam int T_WH_NS       = 12;
  localparam int T_ACC_NS      = 15;
  localparam int T_BDD_NS      = 18;

  // Least time in ns to whole cycles, never below one
  function automatic int ceil_cycles(input int t_ns);
    int r;
    r = (t_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (r < 1) ? 1 : r;
  endfunction : ceil_cycles

  localparam logic [CNT_W-1:0] WP_CYC  = CNT_W'(ceil_cycles(T_WP_NS));
  localparam logic [CNT_W-1:0] WH_CYC  = CNT_W'(ceil_cycles(T_WH_NS));
  localparam logic [CNT_W-1:0] ACC_CYC = CNT_W'(ceil_cycles(T_ACC_NS));
  localparam logic [CNT_W-1:0] BDD_CYC = CNT_W'(ceil_cycles(T_BDD_NS));

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_t;

  typedef struct packed {
    logic              ce_n;
    logic              rw_n;
    logic              oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              data_oe;
  } pins_t;

endpackage : dpram_host_pkg

// file: dpram_port_host.sv
// Host controller for one port of an asynchronous dual-port RAM
`timescale 1ns/100ps
`default_nettype none
module dpram_port_host (
  // Clock and reset
  input  wire logic                              mclk_i,
  input  wire logic                              rst_i,
  // User request
  input  wire logic                              req_valid_i,
  input  wire dpram_host_pkg::req_t              req_i,
  output logic                                   req_ready_o,
  output logic                                   done_o,
  output logic [dpram_host_pkg::DATA_W-1:0]      rdata_o,
  // Configuration
  input  wire logic                              master_sel_i,
  input  wire logic                              busy_ext_n_i,
  // RAM port
  output dpram_host_pkg::pins_t                  pins_o,
  input  wire logic [dpram_host_pkg::DATA_W-1:0] data_i,
  input  wire logic                              busy_n_i,
  output logic                                   busy_n_o,
  output logic                                   busy_oe_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE,
    S_SETUP,
    S_WPULSE,
    S_WEND,
    S_READ
  } state_t;

  state_t                           state;
  logic                             is_wr;
  logic                             busy_act;
  logic                             tload;
  logic [dpram_host_pkg::CNT_W-1:0] tval;
  logic                             tzero;

  // ----------------------------------------------------------------
  // Busy pin direction and sensing
  // ----------------------------------------------------------------
  // Slave side: the master's arbitration verdict is relayed onto the pin
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      busy_n_o  <= 1'b1;
      busy_oe_o <= 1'b0;
    end else begin
      busy_oe_o <= ~master_sel_i;
      busy_n_o  <= master_sel_i ? 1'b1 : busy_ext_n_i;
    end
  end

  // In slave mode the level that gates our write is the one we drive
  assign busy_act = master_sel_i ? ~busy_n_i : ~busy_n_o;

  // ----------------------------------------------------------------
  // Phase timer
  // ----------------------------------------------------------------
  // Busy reloads the hold count, so the strobe outlasts its release
  always_comb begin
    tload = 1'b0;
    tval  = dpram_host_pkg::WP_CYC;
    case (state)
      S_SETUP: begin
        tload = 1'b1;
        tval  = is_wr ? dpram_host_pkg::WP_CYC : dpram_host_pkg::ACC_CYC;
      end
      S_WPULSE: begin
        tload = busy_act;
        tval  = dpram_host_pkg::WH_CYC;
      end
      S_READ: begin
        tload = busy_act;
        tval  = dpram_host_pkg::BDD_CYC;
      end
      default: begin
        tload = 1'b0;
      end
    endcase
  end

  dpram_timer u_timer (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .load_i  (tload),
    .value_i (tval),
    .zero_o  (tzero)
  );

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state          <= S_IDLE;
      is_wr          <= 1'b0;
      req_ready_o    <= 1'b0;
      done_o         <= 1'b0;
      rdata_o        <= '0;
      pins_o.ce_n    <= 1'b1;
      pins_o.rw_n    <= 1'b1;
      pins_o.oe_n    <= 1'b1;
      pins_o.addr    <= '0;
      pins_o.wdata   <= '0;
      pins_o.data_oe <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state)
        S_IDLE: begin
          req_ready_o <= 1'b1;
          if (req_valid_i && req_ready_o) begin
            req_ready_o    <= 1'b0;
            is_wr          <= req_i.wr;
            pins_o.addr    <= req_i.addr;
            pins_o.wdata   <= req_i.data;
            pins_o.data_oe <= req_i.wr;
            pins_o.ce_n    <= 1'b0;
            pins_o.oe_n    <= req_i.wr;
            state          <= S_SETUP;
          end
        end
        // One cycle of address set-up also lets the slave busy settle
        S_SETUP: begin
          if (is_wr) begin
            pins_o.rw_n <= 1'b0;
            state       <= S_WPULSE;
          end else begin
            state <= S_READ;
          end
        end
        S_WPULSE: begin
          if (!busy_act && tzero) begin
            pins_o.rw_n <= 1'b1;
            pins_o.ce_n <= 1'b1;
            state       <= S_WEND;
          end
        end
        S_WEND: begin
          pins_o.data_oe <= 1'b0;
          done_o         <= 1'b1;
          state          <= S_IDLE;
        end
        // Reads are stalled while busy is active, then wait out the BDD count
        S_READ: begin
          if (!busy_act && tzero) begin
            rdata_o     <= data_i;
            pins_o.ce_n <= 1'b1;
            pins_o.oe_n <= 1'b1;
            done_o      <= 1'b1;
            state       <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_busy_release;
    (state == S_WPULSE) && $past(busy_act) && !busy_act;
  endsequence

  property p_slave_busy_before_strobe;
    @(posedge mclk_i) disable iff (rst_i)
    ($fell(pins_o.rw_n) && !master_sel_i && $past(!master_sel_i)
      && $past(!master_sel_i, 2))
      |-> busy_oe_o && $past(busy_oe_o);
  endproperty
  a_slave_busy_before_strobe: assert property (p_slave_busy_before_strobe)
    else $error("Slave busy not driven before write strobe");

  property p_master_no_drive;
    @(posedge mclk_i) disable iff (rst_i)
    (master_sel_i ##1 master_sel_i) |-> !busy_oe_o && busy_n_o;
  endproperty
  a_master_no_drive: assert property (p_master_no_drive)
    else $error("Busy pin driven in master mode");

  property p_hold_after_busy;
    @(posedge mclk_i) disable iff (rst_i)
    (s_busy_release and (!pins_o.rw_n)) |-> (!pins_o.rw_n)[*3];
  endproperty
  a_hold_after_busy: assert property (p_hold_after_busy)
    else $error("Write strobe released too soon after busy");

  property p_hold_master;
    @(posedge mclk_i) disable iff (rst_i)
    (s_busy_release and (master_sel_i && !pins_o.rw_n))
      |-> ##3 (state == S_WPULSE);
  endproperty
  a_hold_master: assert property (p_hold_master)
    else $error("Master mode write hold not kept");

  property p_hold_slave;
    @(posedge mclk_i) disable iff (rst_i)
    (s_busy_release and (!master_sel_i && !pins_o.rw_n))
      |-> ##3 (state == S_WPULSE);
  endproperty
  a_hold_slave: assert property (p_hold_slave)
    else $error("Slave mode write hold not kept");

  property p_strobe_min;
    @(posedge mclk_i) disable iff (rst_i)
    $fell(pins_o.rw_n) |-> (!pins_o.rw_n)[*3];
  endproperty
  a_strobe_min: assert property (p_strobe_min)
    else $error("Write pulse shorter than minimum");

endmodule : dpram_port_host
`default_nettype wire

// file: dpram_timer.sv
// Down counter timing the strobe phases of the port controller
`timescale 1ns/100ps
`default_nettype none
module dpram_timer (
  // Clock and reset
  input  wire logic                             mclk_i,
  input  wire logic                             rst_i,
  // Control
  input  wire logic                             load_i,
  input  wire logic [dpram_host_pkg::CNT_W-1:0] value_i,
  // Status
  output logic                                  zero_o
);

  logic [dpram_host_pkg::CNT_W-1:0] count;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (load_i) begin
      count <= value_i;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign zero_o = (count == '0);

endmodule : dpram_timer
`default_nettype wire

// file: tb.sv
// Self-checking testbench for the dual-port RAM port controller
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed {
    logic        wr;
    logic [12:0] a;
    logic [7:0]  d;
  } row_t;
  logic                  mclk_i       = 1'b0;
  logic                  rst_i        = 1'b1;
  logic                  req_valid_i  = 1'b0;
  logic                  master_sel_i = 1'b1;
  logic                  busy_ext_n_i = 1'b1;
  logic                  contend      = 1'b0;
  dpram_host_pkg::req_t  req_i        = '0;
  dpram_host_pkg::pins_t pins_o;
  logic                  req_ready_o;
  logic                  done_o;
  logic                  busy_n_o;
  logic                  busy_oe_o;
  logic                  dev_busy_n;
  logic                  busy_pin;
  logic [7:0]            rdata_o;
  logic [7:0]            data_i;
  int                    failures = 0;
  int                    n_tests  = 0;
  row_t rows [8] = '{'{1'b1, 13'h0000, 8'h5a}, '{1'b1, 13'h1fff, 8'ha5},
                     '{1'b0, 13'h0000, 8'h5a}, '{1'b0, 13'h1fff, 8'ha5},
                     '{1'b1, 13'h0abc, 8'h3c}, '{1'b0, 13'h0abc, 8'h3c},
                     '{1'b1, 13'h1ffe, 8'hc3}, '{1'b0, 13'h1ffe, 8'hc3}};

  always #2.5 mclk_i = ~mclk_i;
  assign busy_pin = busy_oe_o ? busy_n_o : dev_busy_n;

  dpram_port_host dpram_port_host_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o),
    .rdata_o(rdata_o), .master_sel_i(master_sel_i),
    .busy_ext_n_i(busy_ext_n_i), .pins_o(pins_o), .data_i(data_i),
    .busy_n_i(busy_pin), .busy_n_o(busy_n_o), .busy_oe_o(busy_oe_o));
  dpram_dev_model dpram_dev_model_inst (
    .mclk_i(mclk_i), .pins_i(pins_o), .busy_pin_i(busy_pin),
    .contend_i(contend), .data_o(data_i), .busy_n_o(dev_busy_n));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string what);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    $display("Checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // Held until ready is sampled high, then dropped; done bounded
  task automatic access(input logic wr, input logic [12:0] a,
                        input logic [7:0] d);
    int k;
    k = 0;
    req_i <= '{wr, a, d};
    req_valid_i <= 1'b1;
    do @(posedge mclk_i); while (req_ready_o !== 1'b1 && ++k < 50);
    req_valid_i <= 1'b0;
    do @(posedge mclk_i); while (done_o !== 1'b1 && ++k < 200);
    chk(16'(k < 200), 16'h1, "done");
  endtask : access

  // Busy held by the far side, then released; on writes the strobe must outlast it
  task automatic busy_op(input logic m, input logic wr, input logic [7:0] d);
    int h;
    master_sel_i <= m;
    contend <= m;
    busy_ext_n_i <= m;
    fork
      access(wr, 13'h0005, d);
      begin
        repeat (12) @(posedge mclk_i);
        chk(16'(busy_oe_o), 16'(!m), "busy_oe");
        chk(16'(pins_o.ce_n), 16'h0, "ce_n held");
        chk(16'(pins_o.oe_n), 16'(wr), "oe_n held");
        chk(16'(pins_o.data_oe), 16'(wr), "data_oe held");
        if (wr) chk(16'(pins_o.rw_n), 16'h0, "rw_n held");
        if (!m) chk(16'(busy_n_o), 16'h0, "busy relay");
        contend <= 1'b0;
        busy_ext_n_i <= 1'b1;
        h = 0;
        if (wr) begin
          do @(posedge mclk_i); while (pins_o.rw_n === 1'b0 && ++h < 50);
          chk(16'(h >= 3), 16'h1, "write hold");
        end
      end
    join
    $display("Test busy mode %0d wr %0d done", m, wr);
  endtask : busy_op

  initial begin
    #100000;
    failures++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge mclk_i);
    chk(16'({pins_o.ce_n, pins_o.rw_n, pins_o.oe_n, pins_o.data_oe}),
        16'he, "reset pins");
    chk(16'({req_ready_o, done_o, busy_oe_o, busy_n_o}), 16'h1,
        "reset status");
    chk(16'(rdata_o), 16'h0, "reset rdata");
    chk(16'({dpram_dev_model_inst.own_int_n, dpram_dev_model_inst.peer_int_n}),
        16'h1, "mail flags");
    rst_i <= 1'b0;
    $display("Test reset done");
    foreach (rows[i]) begin
      access(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(16'(rdata_o), 16'(rows[i].d), "rdata");
    end
    chk(16'({dpram_dev_model_inst.own_int_n, dpram_dev_model_inst.peer_int_n}),
        16'h2, "mail flags");
    $display("Test rows done");
    for (int m = 1; m >= 0; m--) begin
      busy_op(m[0], 1'b1, m[0] ? 8'h77 : 8'h88);
      access(1'b0, 13'h0005, 8'h00);
      chk(16'(rdata_o), m[0] ? 16'h77 : 16'h88, "busy write");
    end
    busy_op(1'b1, 1'b0, 8'h00);
    chk(16'(rdata_o), 16'h88, "busy read");
    final_report();
  end
endmodule : tb
`default_nettype wire
